// ==== hw/see_pkg.sv ====
// package of constants for the serial eeprom command engine
// Operation
// - after the first read word, keep shifting further words while select stays high
// - sequential read increments address and wraps from last location to zero
// - only the first read word is preceded by a zero dummy bit
// - select falling after a write starts a self-timed clear-and-store cycle
// - a started program or clear cycle completes with no serial clock
// - host may raise select during or after a cycle to see ready/busy
// - write clears the location itself before storing, no erase needed
// - select falling after erase starts a self-timed clear of that location
// - a cleared location reads back as all ones
// - power-up leaves the device write-disabled
// - write enable holds until reset or write-disable instruction
// - while disabled, write, erase, clear-all and fill-all leave the array unchanged
// - reads work whatever the write-enable latch holds
// - select falling after clear-all clears every location to ones
// - select falling after fill-all writes its data to every location
// - small variant: select falling outside that window programs nothing
// - select high after a cycle starts: output low while busy, high when ready
// - serial data in is sampled on the rising serial clock edge
// - instruction is start bit one, opcode, address, then data for writes
// - read outputs one zero dummy bit then the word msb first
package see_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);
  // ****************************************
  // geometry and instruction format
  // ****************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int OPC_W = 2;
  localparam int DEPTH = 64;
  // ****************************************
  // opcodes (two bits after the start bit)
  // ****************************************
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  // extended sub-codes: top two address bits
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_FILL_ALL = 2'h1;
  localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic WEN_RESET = 1'b0;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // self-timed cycle kinds
  typedef enum logic [1:0] {SEE_JOB_WRITE, SEE_JOB_ERASE, SEE_JOB_FILL, SEE_JOB_CLEAR} see_job_e;
endpackage

// ==== hw/see_buf2.sv ====
// two-entry valid/ready buffer
`timescale 1ns/1ps
module see_buf2 #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  initial begin
    if (WIDTH < 1) $error("see_buf2: WIDTH must be positive");
  end
  logic [WIDTH-1:0] slot [2];
  logic [1:0] count;
  logic rd_ptr;
  logic wr_ptr;
  logic push;
  logic pop;
  // full and empty follow the count directly
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end
  // pointers and occupancy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end
endmodule

// ==== hw/see_array.sv ====
// word array with single-word and whole-array writes
`timescale 1ns/1ps
module see_array #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write port
  input wire logic wr_one,
  input wire logic wr_all,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  initial begin
    if (AW < 1 || DW < 1) $error("see_array: bad geometry");
  end
  logic [DW-1:0] mem [2**AW];
  assign rd_data = mem[rd_addr];
  // erased state is all ones, so reset fills ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 2**AW; i++) mem[i] <= '1;
    end else begin
      for (int i = 0; i < 2**AW; i++) begin
        if (wr_all || (wr_one && wr_addr == AW'(i))) mem[i] <= wr_data;
      end
    end
  end
endmodule

// ==== hw/see_engine.sv ====
// command engine of the serial eeprom
`timescale 1ns/1ps
module see_engine #(
  parameter int PROG_CYCLES = see_pkg::PROG_CYCLES,
  parameter bit SMALL_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // serial link, sampled synchronously
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA_IN,
  // serial data out with its enable
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE,
  // status
  output logic WRITE_ENABLED,
  output logic BUSY
);
  // ****************************************
  // overview
  // ****************************************
  // the link pins are plain levels sampled on the system clock, so a serial
  // clock rise is seen as a low sample followed by a high one; the host must
  // hold every serial level for at least one system clock or a rise is lost
  //
  // a frame is a start bit, a two-bit opcode, the address, and for write and
  // fill-all a data word; a frame other than a read is only acted on when select
  // falls, which is what starts the self-timed cycle
  //
  // the self-timed cycle counts system clocks, not serial clocks, so the host
  // may stop the link clock entirely while it waits
  //
  // reads prefetch words into a two-entry buffer so that the shifter always
  // has the next word ready at the word boundary; a running cycle may still commit
  // to the array during a read, so a prefetched word can go stale
  //
  // limitation: only the sixteen-bit organisation is built; the width select
  // pin of the real part is not modelled
  //
  // trade-off: the commit to the array happens in one clock at the end of the
  // cycle, which keeps the array simple; a reset in mid-cycle fills every
  // location with ones, as any reset does, so nothing is left half cleared
  //
  // ****************************************
  // derived sizes
  // ****************************************
  localparam int AW = see_pkg::ADDR_W;
  localparam int DW = see_pkg::DATA_W;
  localparam int CMD_W = 1 + see_pkg::OPC_W + AW;
  initial begin
    if (PROG_CYCLES < 1) $error("see_engine: PROG_CYCLES must be at least one");
  end
  // ****************************************
  // link edge detection
  // ****************************************
  typedef enum logic [2:0] {SEE_HUNT, SEE_CMD, SEE_DATA, SEE_ARMED, SEE_READ, SEE_IGNORE}
    see_state_e;
  see_state_e state;
  logic cs_q;
  logic sk_q;
  logic sk_rise;
  logic sk_fall;
  logic cs_rise;
  logic cs_fall;
  logic [CMD_W-1:0] cmd;
  logic [4:0] bitcnt;
  logic [DW-1:0] data_sr;
  logic [AW-1:0] addr;
  logic [1:0] opc;
  logic prog_run;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt;
  see_pkg::see_job_e job;
  logic [AW-1:0] job_addr;
  logic [DW-1:0] job_data;
  logic window_open;
  logic wen;
  logic [DW-1:0] rd_word;
  logic [DW-1:0] out_sr;
  logic [4:0] out_cnt;
  logic dummy_sent;
  logic word_ready;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DW-1:0] buf_out_data;
  logic buf_pop;
  logic buf_push;
  logic start_job;
  logic do_one;
  logic do_all;
  logic [DW-1:0] wr_val;
  // read address and prefetch request, declared here as the array reads them
  logic [AW-1:0] rd_addr_q;
  logic fetch_pending;
  // previous link levels
  // select and serial clock both reset low, their idle levels, so no false
  // edge is seen straight after reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cs_q <= 1'b0;
      sk_q <= 1'b0;
    end else begin
      cs_q <= CHIP_SELECT;
      sk_q <= SERIAL_CLOCK;
    end
  end
  assign sk_rise = CHIP_SELECT && SERIAL_CLOCK && !sk_q;
  assign sk_fall = CHIP_SELECT && !SERIAL_CLOCK && sk_q;
  assign cs_rise = CHIP_SELECT && !cs_q;
  assign cs_fall = !CHIP_SELECT && cs_q;
  assign opc = cmd[AW +: 2];
  assign addr = cmd[AW-1:0];
  // ****************************************
  // instruction decoder
  // ****************************************
  // bits shift on rising serial clock only
  // a low select wins over everything, so a cut frame always returns to hunt
  // bitcnt counts the start bit too, so the opcode decode sees the last
  // address bit on the wire rather than in cmd
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= SEE_HUNT;
      cmd <= '0;
      bitcnt <= 5'h0;
      data_sr <= '0;
      window_open <= 1'b0;
    end else if (!CHIP_SELECT) begin
      state <= SEE_HUNT; // deselect ends any frame
      bitcnt <= 5'h0;
      window_open <= 1'b0;
    end else if (cs_rise) begin
      state <= SEE_HUNT;
      bitcnt <= 5'h0;
    end else if (sk_rise) begin
      unique case (state)
        SEE_HUNT: begin
          if (SERIAL_DATA_IN) begin
            state <= SEE_CMD; // leading one is the start bit
            cmd <= {{(CMD_W-1){1'b0}}, 1'b1};
            bitcnt <= 5'h1;
          end
        end
        SEE_CMD: begin
          cmd <= {cmd[CMD_W-2:0], SERIAL_DATA_IN};
          bitcnt <= bitcnt + 5'h1;
          if (bitcnt == 5'(CMD_W - 1)) begin
            bitcnt <= 5'h0;
            unique case (cmd[AW-1 +: 2])
              see_pkg::OPC_READ: state <= SEE_READ;
              see_pkg::OPC_WRITE: state <= SEE_DATA;
              see_pkg::OPC_ERASE: begin
                state <= SEE_ARMED;
                window_open <= 1'b1;
              end
              see_pkg::OPC_EXT: begin
                if (cmd[AW-2 -: 2] == see_pkg::EXT_FILL_ALL) state <= SEE_DATA;
                else begin
                  state <= SEE_ARMED;
                  window_open <= 1'b1;
                end
              end
            endcase
          end
        end
        SEE_DATA: begin
          data_sr <= {data_sr[DW-2:0], SERIAL_DATA_IN};
          bitcnt <= bitcnt + 5'h1;
          if (bitcnt == 5'(DW - 1)) begin
            state <= SEE_ARMED;
            window_open <= 1'b1;
          end
        end
        SEE_ARMED: begin
          // a further rising edge closes the small part's window
          window_open <= 1'b0;
          state <= SEE_IGNORE;
        end
        SEE_READ, SEE_IGNORE: begin
        end
      endcase
    end
  end
  // ****************************************
  // write-enable latch
  // ****************************************
  // cleared only by reset or the disable instruction
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wen <= see_pkg::WEN_RESET;
    end else if (cs_fall && !prog_run && (state == SEE_ARMED || state == SEE_IGNORE)
                 && opc == see_pkg::OPC_EXT) begin
      // instructions other than reads are ignored while a cycle runs, the latch included
      if (addr[AW-1 -: 2] == see_pkg::EXT_ENABLE) wen <= 1'b1;
      else if (addr[AW-1 -: 2] == see_pkg::EXT_DISABLE) wen <= 1'b0;
    end
  end
  // ****************************************
  // self-timed program cycle
  // ****************************************
  // launched by select falling, gated by the latch and, in the small variant only, the window
  assign start_job = cs_fall && wen && !prog_run
    && (state == SEE_ARMED || (!SMALL_VARIANT && state == SEE_IGNORE))
    && (window_open || !SMALL_VARIANT)
    && !(opc == see_pkg::OPC_EXT
         && (addr[AW-1 -: 2] == see_pkg::EXT_ENABLE || addr[AW-1 -: 2] == see_pkg::EXT_DISABLE));
  // counts on the system clock, needs no serial clock
  // the count is loaded with one less than the length because the clock that
  // reaches zero is itself the commit clock
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prog_run <= 1'b0;
      prog_cnt <= '0;
      job <= see_pkg::SEE_JOB_WRITE;
      job_addr <= '0;
      job_data <= '0;
    end else if (start_job) begin
      prog_run <= 1'b1;
      prog_cnt <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES - 1);
      job_addr <= addr;
      job_data <= data_sr;
      unique case (opc)
        see_pkg::OPC_WRITE: job <= see_pkg::SEE_JOB_WRITE;
        see_pkg::OPC_ERASE: job <= see_pkg::SEE_JOB_ERASE;
        default: begin
          if (addr[AW-1 -: 2] == see_pkg::EXT_FILL_ALL) job <= see_pkg::SEE_JOB_FILL;
          else job <= see_pkg::SEE_JOB_CLEAR;
        end
      endcase
    end else if (prog_run) begin
      if (prog_cnt == '0) prog_run <= 1'b0;
      else prog_cnt <= prog_cnt - 1'b1;
    end
  end
  // commit at the end of the cycle; a write overwrites the whole word, so no erase first
  assign do_one = prog_run && prog_cnt == '0
    && (job == see_pkg::SEE_JOB_WRITE || job == see_pkg::SEE_JOB_ERASE);
  assign do_all = prog_run && prog_cnt == '0
    && (job == see_pkg::SEE_JOB_FILL || job == see_pkg::SEE_JOB_CLEAR);
  // erased words read as ones
  assign wr_val = (job == see_pkg::SEE_JOB_ERASE || job == see_pkg::SEE_JOB_CLEAR)
    ? see_pkg::ERASED_WORD : job_data;
  see_array #(
    .AW(AW),
    .DW(DW)
  ) u_array (
    .clk(CLK),
    .nrst(NRST),
    .wr_one(do_one),
    .wr_all(do_all),
    .wr_addr(job_addr),
    .wr_data(wr_val),
    .rd_addr(rd_addr_q),
    .rd_data(rd_word)
  );
  // ****************************************
  // sequential read path
  // ****************************************
  // fetch words into the buffer; address wraps naturally past the top
  // the first address is taken from the wire on the last command bit so
  // the first word is fetched while the dummy bit is being shown
  assign buf_push = fetch_pending;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rd_addr_q <= '0;
      fetch_pending <= 1'b0;
    end else if (state == SEE_CMD && sk_rise && bitcnt == 5'(CMD_W - 1)
                 && cmd[AW-1 +: 2] == see_pkg::OPC_READ) begin
      rd_addr_q <= {cmd[AW-2:0], SERIAL_DATA_IN};
      fetch_pending <= 1'b1;
    end else if (state != SEE_READ) begin
      fetch_pending <= 1'b0;
    end else if (fetch_pending && buf_in_ready) begin
      rd_addr_q <= rd_addr_q + 1'b1;
    end
  end
  // buffer keeps the next word ready while the shifter drains the current one
  see_buf2 #(
    .WIDTH(DW)
  ) u_buf (
    .clk(CLK),
    .nrst(NRST),
    .in_valid(buf_push && state == SEE_READ),
    .in_ready(buf_in_ready),
    .in_data(rd_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop || state != SEE_READ),
    .out_data(buf_out_data)
  );
  // ****************************************
  // output shifter and ready/busy
  // ****************************************
  // the buffer refills within two clocks of a pop, far inside one serial bit
  assign word_ready = buf_out_valid;
  assign buf_pop = state == SEE_READ && sk_rise && dummy_sent && out_cnt == 5'h0 && word_ready;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OE <= 1'b0;
      out_sr <= '0;
      out_cnt <= 5'h0;
      dummy_sent <= 1'b0;
    end else if (!CHIP_SELECT) begin
      SERIAL_DATA_OE <= 1'b0;
      dummy_sent <= 1'b0;
      out_cnt <= 5'h0;
    end else if (state == SEE_READ) begin
      if (!dummy_sent) begin
        SERIAL_DATA_OE <= 1'b1;
        SERIAL_DATA_OUT <= 1'b0; // single zero dummy bit
        dummy_sent <= 1'b1;
      end else if (sk_rise) begin
        if (out_cnt == 5'h0) begin
          SERIAL_DATA_OUT <= buf_out_data[DW-1]; // msb first
          out_sr <= {buf_out_data[DW-2:0], 1'b0};
          out_cnt <= 5'(DW - 1); // next word follows with no dummy
        end else begin
          SERIAL_DATA_OUT <= out_sr[DW-1];
          out_sr <= {out_sr[DW-2:0], 1'b0};
          out_cnt <= out_cnt - 5'h1;
        end
      end
    end else if (state == SEE_HUNT && bitcnt == 5'h0 && !SERIAL_DATA_IN && sk_fall == 1'b0
                 && !cs_rise) begin
      // polling: low while busy, high when ready
      SERIAL_DATA_OE <= 1'b1;
      SERIAL_DATA_OUT <= !prog_run;
    end else if (sk_fall) begin
      SERIAL_DATA_OE <= 1'b0; // a one shifted in releases the pin
    end
  end
  // status pins from flip-flops
  // both lag their internal state by one clock so that every top-level
  // output comes straight from a register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WRITE_ENABLED <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      WRITE_ENABLED <= wen;
      BUSY <= prog_run;
    end
  end
endmodule

// ==== bench/see_checker.sv ====
// assertion checker for the serial eeprom command engine
`timescale 1ns/1ps
module see_checker #(
  parameter int PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // serial link
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA_IN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OE,
  // status
  input wire logic WRITE_ENABLED,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ****************
  // helper logic
  // ****************
  int busy_len;
  // clocks spent in the current self-timed cycle; cleared whenever idle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy_len <= 0;
    end else if (BUSY) begin
      busy_len <= busy_len + 1;
    end else begin
      busy_len <= 0;
    end
  end
  // ****************
  // sequences
  // ****************
  // output enabled, idle and no serial rise for four clocks
  sequence s_quiet;
    (!SERIAL_CLOCK && SERIAL_DATA_OE && !BUSY)[*4];
  endsequence
  // select held low for three clocks
  sequence s_deselected;
    (!CHIP_SELECT)[*3];
  endsequence
  // ****************
  // assertions
  // ****************
  a_busy_start: assert property ($rose(BUSY) |-> !$past(CHIP_SELECT))
    else $error("busy rose while select was high");
  a_busy_locked: assert property ($rose(BUSY) |-> WRITE_ENABLED)
    else $error("cycle started while write disabled");
  a_cycle_ends: assert property (busy_len <= PROG_CYCLES + 1)
    else $error("self-timed cycle overran");
  a_cycle_full: assert property ($fell(BUSY) |-> busy_len >= PROG_CYCLES - 1)
    else $error("self-timed cycle cut short");
  a_poll_busy: assert property (BUSY && $past(BUSY) && SERIAL_DATA_OE |-> !SERIAL_DATA_OUT)
    else $error("ready shown while busy");
  a_oe_off: assert property (s_deselected |-> !SERIAL_DATA_OE)
    else $error("output driven while deselected");
  a_wen_powerup: assert property (!$past(NRST) |-> !WRITE_ENABLED && !BUSY)
    else $error("write enabled after reset");
  a_out_holds: assert property (s_quiet |-> $stable(SERIAL_DATA_OUT))
    else $error("data out moved without serial rise");
  a_wen_idle: assert property ($changed(WRITE_ENABLED) |-> !$past(BUSY))
    else $error("enable latch changed during cycle");
endmodule

bind see_engine see_checker #(.PROG_CYCLES(PROG_CYCLES)) see_checker_i (
  .CLK(CLK),
  .NRST(NRST),
  .CHIP_SELECT(CHIP_SELECT),
  .SERIAL_CLOCK(SERIAL_CLOCK),
  .SERIAL_DATA_IN(SERIAL_DATA_IN),
  .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .SERIAL_DATA_OE(SERIAL_DATA_OE),
  .WRITE_ENABLED(WRITE_ENABLED),
  .BUSY(BUSY)
);

// ==== bench/see_host.sv ====
// host-side model that drives the serial link of the eeprom engine
`timescale 1ns/1ps
module see_host (
  // system clock, paces the link
  input wire logic clk,
  // link driven by the host
  output logic cs,
  output logic sk,
  output logic di,
  // link driven by the device
  input wire logic dout,
  input wire logic doe
);
  // link idles with clock stopped low and select low
  initial begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
  end
  // one bit: data moves only while clock is low, each level held two clocks
  task automatic sk_bit(input logic b, output logic q);
    di = b;
    repeat (2) @(negedge clk);
    sk = 1'b1;
    repeat (2) @(negedge clk);
    q = dout;
    sk = 1'b0;
  endtask
  // select, start bit, opcode and address
  task automatic cmd(input logic [1:0] opc, input logic [5:0] a);
    logic q;
    cs = 1'b1;
    sk_bit(1'b1, q);
    for (int i = 1; i >= 0; i--) sk_bit(opc[i], q);
    for (int i = 5; i >= 0; i--) sk_bit(a[i], q);
  endtask
  // sixteen data bits, msb first
  task automatic data16(input logic [15:0] d);
    logic q;
    for (int i = 15; i >= 0; i--) sk_bit(d[i], q);
  endtask
  // drop select in the same step as the clock falls, keeping the tight window
  task automatic deselect();
    cs = 1'b0;
    di = ~di;
    repeat (8) @(negedge clk);
  endtask
  // select with data in low and read ready/busy; select is left high
  task automatic poll(output logic q);
    cs = 1'b1;
    di = 1'b0;
    repeat (4) @(negedge clk);
    q = dout;
  endtask
endmodule

// ==== bench/tb_top.sv ====
// self-checking testbench for the serial eeprom command engine
`timescale 1ns/1ps
module tb_top;
  localparam int PROG = 20;
  logic clk;
  logic nrst;
  wire cs;
  wire sk;
  wire di;
  logic dout;
  logic doe;
  logic wen;
  logic busy;
  logic [15:0] mem [64];
  int miscompares;
  int checked;
  // short program time keeps the run brief
  see_engine #(.PROG_CYCLES(PROG), .SMALL_VARIANT(1'b1)) see_engine_i (
    .CLK(clk),
    .NRST(nrst),
    .CHIP_SELECT(cs),
    .SERIAL_CLOCK(sk),
    .SERIAL_DATA_IN(di),
    .SERIAL_DATA_OUT(dout),
    .SERIAL_DATA_OE(doe),
    .WRITE_ENABLED(wen),
    .BUSY(busy)
  );
  see_host see_host_i (
    .clk(clk),
    .cs(cs),
    .sk(sk),
    .di(di),
    .dout(dout),
    .doe(doe)
  );
  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // sequential read of n words against the shadow array
  task automatic read_chk(input logic [5:0] a, input int n);
    logic [15:0] w;
    logic q;
    see_host_i.cmd(see_pkg::OPC_READ, a);
    chk({14'h0000, doe, dout}, 16'h0002);
    for (int k = 0; k < n; k++) begin
      for (int i = 15; i >= 0; i--) begin
        see_host_i.sk_bit(1'b0, q);
        w[i] = q;
      end
      chk(w, mem[6'(a + k)]);
    end
    see_host_i.deselect();
  endtask
  // one program-type frame, then busy and ready/busy polling
  task automatic prog(input logic [1:0] opc, input logic [5:0] a, input logic [15:0] d,
      input logic with_data, input logic extra, input logic go);
    logic q;
    int n;
    see_host_i.cmd(opc, a);
    if (with_data) see_host_i.data16(d);
    if (extra) see_host_i.sk_bit(1'b0, q);
    see_host_i.deselect();
    chk({15'h0000, busy}, {15'h0000, go});
    see_host_i.poll(q);
    chk({15'h0000, q}, {15'h0000, !go});
    see_host_i.deselect();
    n = 0;
    // the link clock stays stopped while the cycle runs
    while (busy !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, busy}, 16'h0000);
    see_host_i.poll(q);
    chk({15'h0000, q}, 16'h0001);
    see_host_i.deselect();
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_locked();
    chk({15'h0000, wen}, 16'h0000);
    read_chk(6'h05, 1);
    prog(see_pkg::OPC_WRITE, 6'h05, 16'h1234, 1'b1, 1'b0, 1'b0);
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_FILL_ALL, 4'h0}, 16'h0000, 1'b1, 1'b0, 1'b0);
    read_chk(6'h05, 1);
  endtask
  task automatic t_write();
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_ENABLE, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
    chk({15'h0000, wen}, 16'h0001);
    prog(see_pkg::OPC_WRITE, 6'h3F, 16'hA5C3, 1'b1, 1'b0, 1'b1);
    prog(see_pkg::OPC_WRITE, 6'h00, 16'h1234, 1'b1, 1'b0, 1'b1);
    prog(see_pkg::OPC_WRITE, 6'h3F, 16'h0F0F, 1'b1, 1'b0, 1'b1);
    mem[63] = 16'h0F0F;
    mem[0] = 16'h1234;
    read_chk(6'h3F, 3);
  endtask
  task automatic t_erase();
    prog(see_pkg::OPC_ERASE, 6'h00, 16'h0000, 1'b0, 1'b0, 1'b1);
    mem[0] = 16'hFFFF;
    read_chk(6'h3F, 2);
    chk({15'h0000, wen}, 16'h0001);
  endtask
  task automatic t_window();
    prog(see_pkg::OPC_WRITE, 6'h21, 16'h0000, 1'b1, 1'b1, 1'b0);
    prog(see_pkg::OPC_WRITE, 6'h07, 16'h0000, 1'b0, 1'b0, 1'b0);
    read_chk(6'h21, 1);
    read_chk(6'h07, 1);
  endtask
  task automatic t_bulk();
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_FILL_ALL, 4'h0}, 16'h5A5A, 1'b1, 1'b0, 1'b1);
    foreach (mem[i]) mem[i] = 16'h5A5A;
    read_chk(6'h3E, 3);
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_CLEAR_ALL, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b1);
    foreach (mem[i]) mem[i] = 16'hFFFF;
    read_chk(6'h10, 2);
  endtask
  task automatic t_disable();
    prog(see_pkg::OPC_WRITE, 6'h10, 16'h00C3, 1'b1, 1'b0, 1'b1);
    mem[16] = 16'h00C3;
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_DISABLE, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
    chk({15'h0000, wen}, 16'h0000);
    prog(see_pkg::OPC_ERASE, 6'h10, 16'h0000, 1'b0, 1'b0, 1'b0);
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_CLEAR_ALL, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
    read_chk(6'h10, 1);
  endtask
  task automatic t_reset_again();
    prog(see_pkg::OPC_EXT, {see_pkg::EXT_ENABLE, 4'h0}, 16'h0000, 1'b0, 1'b0, 1'b0);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    foreach (mem[i]) mem[i] = 16'hFFFF;
    chk({15'h0000, wen}, 16'h0000);
    read_chk(6'h10, 1);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    nrst = 1'b0;
    miscompares = 0;
    checked = 0;
    foreach (mem[i]) mem[i] = 16'hFFFF;
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_locked();
    t_write();
    t_erase();
    t_window();
    t_bulk();
    t_disable();
    t_reset_again();
    wrap_up();
  end
  // watchdog: the full sequence needs well under half this span
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
